// file: logic/pclpc_regs.svh
// Register offsets, field positions, reset values and bus codes of the clock control block
`ifndef PCLPC_REGS_SVH
`define PCLPC_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PCLPC_ADDR_W            8
`define PCLPC_OFS_PLL_CONTROL   8'h00
`define PCLPC_OFS_CONFIG        8'h04
`define PCLPC_OFS_BREAK_FLAG    8'h08
`define PCLPC_OFS_STATUS        8'h0c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PCLPC_PLLCTRL_IE_BIT    0
`define PCLPC_PLLCTRL_FLAG_BIT  1
`define PCLPC_PLLCTRL_LOCK_BIT  2
`define PCLPC_PLLCTRL_BSS_BIT   3
`define PCLPC_PLLCTRL_PON_BIT   4
`define PCLPC_CONFIG_ORS_BIT    0
`define PCLPC_BRK_BCE_BIT       0
`define PCLPC_STAT_MODE_LSB     0
`define PCLPC_STAT_OSC_BIT      2
`define PCLPC_STAT_PLL_BIT      3
`define PCLPC_STAT_BUSCLK_BIT   4
`define PCLPC_STAT_BREAK_BIT    5

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PCLPC_RST_IE            1'b0
`define PCLPC_RST_BSS           1'b0
`define PCLPC_RST_PON           1'b1
`define PCLPC_RST_ORS           1'b0
`define PCLPC_RST_BCE           1'b0

// ----------------------------------------------------------------
// Bus response codes
// ----------------------------------------------------------------
`define PCLPC_RESP_OKAY         2'b00
`define PCLPC_RESP_SLVERR       2'b10

`endif

// file: logic/pclpc_pkg.sv
// Types of the clock control block
package pclpc_pkg;

  typedef enum logic [1:0] {
    PCLPC_RUN,
    PCLPC_WAIT,
    PCLPC_STOP
  } pclpc_mode_t;

  typedef struct packed {
    pclpc_mode_t mode;
    logic        pll_ie;
    logic        pll_interrupt_flag;
    logic        bus_source_select;
    logic        pll_power_on;
    logic        osc_run_in_stop;
    logic        break_clear_enable;
    logic        lock_q;
    logic        aw_have;
    logic [7:0]  awaddr;
    logic        w_have;
    logic [7:0]  wdata;
    logic        wstrb0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } pclpc_state_t;

endpackage

// file: logic/pclpc_sync.sv
// Three-stage synchroniser for asynchronous inputs
`timescale 1ns/1ns
module pclpc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk_i,
  input  wire logic             arst_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] stage2_o,
  output logic      [WIDTH-1:0] stage3_o
);

  // ----------------------------------------------------------------
  // Per-bit flop chain
  // ----------------------------------------------------------------
  for (genvar gi = 0; gi < WIDTH; gi++) begin : g_bit
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        s1_ff <= 1'b0;
        s2_ff <= 1'b0;
        s3_ff <= 1'b0;
      end else begin
        s1_ff <= async_i[gi];
        s2_ff <= s1_ff;
        s3_ff <= s2_ff;
      end
    end
    assign stage2_o[gi] = s2_ff;
    assign stage3_o[gi] = s3_ff;
  end

endmodule

// file: logic/pclpc_top.sv
// Clock generator control for wait, stop and break states with an AXI4-Lite register port
//
// Notes on behaviour
// - A write selecting the PLL clock as bus source is taken even while lock reads zero.
// - Entering wait changes nothing in oscillator, PLL or bus clock source.
// - Clearing source select and PLL power-on disengages the PLL and powers it down.
// - A PLL left powered but disengaged keeps running through wait for instant reuse.
// - With interrupt enable set, a powered PLL raises its interrupt on lock gained or lost and that wakes the core from wait.
// - With run-in-stop clear, stop turns off oscillator and PLL and holds all clock outputs low.
// - Stop while the PLL clock drives the bus clears source select, falling back to crystal clock.
// - After stop the bus runs from the crystal clock and source select stays clear until rewritten.
// - With run-in-stop set, stop turns off the PLL while the oscillator keeps running.
// - With break clear enabled, a flag cleared during break stays cleared after break.
// - With break clear disabled, register accesses during break leave the PLL flag untouched.
`timescale 1ns/1ns
`include "pclpc_regs.svh"
module pclpc_top (
  input  wire logic        core_clk_i,
  input  wire logic        arst_n_i,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // Core and system integration unit
  input  wire logic        wait_exec_i,
  input  wire logic        stop_exec_i,
  input  wire logic        stop_wake_i,
  input  wire logic        wait_wake_i,
  input  wire logic        break_state_i,
  // Analog PLL and oscillator
  input  wire logic        pll_lock_i,
  output logic             osc_enable_o,
  output logic             pll_enable_o,
  output logic             bus_source_select_o,
  output logic             crystal_clock_en_o,
  output logic             bus_clock_source_out_en_o,
  output logic             clock_gen_interrupt_o,
  output logic             wake_from_wait_o
);

  // ----------------------------------------------------------------
  // State and lock synchroniser
  // ----------------------------------------------------------------
  pclpc_pkg::pclpc_state_t st_ff;
  pclpc_pkg::pclpc_state_t nxt_st;
  logic                    lock_s2;
  logic                    lock_s3;
  logic                    stopped_off;
  logic                    in_stop;
  logic                    irq_raw;
  logic                    do_wr;
  logic                    wr_ok;
  logic                    rd_ok;
  logic                    clr_allowed;
  logic                    flag_set;
  logic [31:0]             rd_word;

  pclpc_sync #(
    .WIDTH (1)
  ) u_lock_sync (
    .core_clk_i (core_clk_i),
    .arst_n_i   (arst_n_i),
    .async_i    (pll_lock_i),
    .stage2_o   (lock_s2),
    .stage3_o   (lock_s3)
  );

  // ----------------------------------------------------------------
  // Clock outputs
  // ----------------------------------------------------------------
  assign in_stop     = (st_ff.mode == pclpc_pkg::PCLPC_STOP);
  assign stopped_off = in_stop && !st_ff.osc_run_in_stop;
  assign irq_raw     = st_ff.pll_interrupt_flag && st_ff.pll_ie;

  assign osc_enable_o              = !stopped_off;
  assign pll_enable_o              = st_ff.pll_power_on && !in_stop;
  assign bus_source_select_o       = st_ff.bus_source_select;
  assign crystal_clock_en_o        = !stopped_off;
  assign bus_clock_source_out_en_o = !stopped_off;
  assign clock_gen_interrupt_o     = irq_raw && !stopped_off;
  assign wake_from_wait_o          = (st_ff.mode == pclpc_pkg::PCLPC_WAIT) && irq_raw;

  // ----------------------------------------------------------------
  // Bus handshakes and outputs
  // ----------------------------------------------------------------
  assign s_axi_awready_o = !st_ff.aw_have;
  assign s_axi_wready_o  = !st_ff.w_have;
  assign s_axi_arready_o = !st_ff.rvalid;
  assign s_axi_bvalid_o  = st_ff.bvalid;
  assign s_axi_bresp_o   = st_ff.bresp;
  assign s_axi_rvalid_o  = st_ff.rvalid;
  assign s_axi_rresp_o   = st_ff.rresp;
  assign s_axi_rdata_o   = st_ff.rdata;

  // ----------------------------------------------------------------
  // Read data mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    case (s_axi_araddr_i)
      `PCLPC_OFS_PLL_CONTROL: begin
        rd_word[`PCLPC_PLLCTRL_IE_BIT]   = st_ff.pll_ie;
        rd_word[`PCLPC_PLLCTRL_FLAG_BIT] = st_ff.pll_interrupt_flag;
        rd_word[`PCLPC_PLLCTRL_LOCK_BIT] = st_ff.lock_q;
        rd_word[`PCLPC_PLLCTRL_BSS_BIT]  = st_ff.bus_source_select;
        rd_word[`PCLPC_PLLCTRL_PON_BIT]  = st_ff.pll_power_on;
      end
      `PCLPC_OFS_CONFIG: begin
        rd_word[`PCLPC_CONFIG_ORS_BIT] = st_ff.osc_run_in_stop;
      end
      `PCLPC_OFS_BREAK_FLAG: begin
        rd_word[`PCLPC_BRK_BCE_BIT] = st_ff.break_clear_enable;
      end
      `PCLPC_OFS_STATUS: begin
        rd_word[`PCLPC_STAT_MODE_LSB +: 2] = st_ff.mode;
        rd_word[`PCLPC_STAT_OSC_BIT]       = osc_enable_o;
        rd_word[`PCLPC_STAT_PLL_BIT]       = pll_enable_o;
        rd_word[`PCLPC_STAT_BUSCLK_BIT]    = bus_clock_source_out_en_o;
        rd_word[`PCLPC_STAT_BREAK_BIT]     = break_state_i;
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st      = st_ff;
    do_wr       = st_ff.aw_have && st_ff.w_have && !st_ff.bvalid;
    wr_ok       = 1'b0;
    clr_allowed = !break_state_i || st_ff.break_clear_enable;
    flag_set    = 1'b0;

    // Lock level counts once stages two and three agree
    if (lock_s2 == lock_s3) begin
      nxt_st.lock_q = lock_s3;
    end
    if (st_ff.pll_power_on && !in_stop && (nxt_st.lock_q != st_ff.lock_q)) begin
      flag_set = 1'b1;
    end

    // Write channel capture
    if (s_axi_awvalid_i && !st_ff.aw_have) begin
      nxt_st.aw_have = 1'b1;
      nxt_st.awaddr  = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && !st_ff.w_have) begin
      nxt_st.w_have = 1'b1;
      nxt_st.wdata  = s_axi_wdata_i[7:0];
      nxt_st.wstrb0 = s_axi_wstrb_i[0];
    end
    if (st_ff.bvalid && s_axi_bready_i) begin
      nxt_st.bvalid = 1'b0;
    end

    // Register write; flag bit is read-only so writes never touch it
    if (do_wr) begin
      nxt_st.aw_have = 1'b0;
      nxt_st.w_have  = 1'b0;
      nxt_st.bvalid  = 1'b1;
      case (st_ff.awaddr)
        `PCLPC_OFS_PLL_CONTROL: begin
          wr_ok = 1'b1;
          if (st_ff.wstrb0) begin
            nxt_st.pll_ie            = st_ff.wdata[`PCLPC_PLLCTRL_IE_BIT];
            nxt_st.bus_source_select = st_ff.wdata[`PCLPC_PLLCTRL_BSS_BIT];
            nxt_st.pll_power_on      = st_ff.wdata[`PCLPC_PLLCTRL_PON_BIT];
          end
        end
        `PCLPC_OFS_CONFIG: begin
          wr_ok = 1'b1;
          if (st_ff.wstrb0) begin
            nxt_st.osc_run_in_stop = st_ff.wdata[`PCLPC_CONFIG_ORS_BIT];
          end
        end
        `PCLPC_OFS_BREAK_FLAG: begin
          wr_ok = 1'b1;
          if (st_ff.wstrb0) begin
            nxt_st.break_clear_enable = st_ff.wdata[`PCLPC_BRK_BCE_BIT];
          end
        end
        `PCLPC_OFS_STATUS: begin
          wr_ok = 1'b1;
        end
        default: begin
          wr_ok = 1'b0;
        end
      endcase
      nxt_st.bresp = wr_ok ? `PCLPC_RESP_OKAY : `PCLPC_RESP_SLVERR;
    end

    // Read channel; a control register read clears the flag when allowed
    if (st_ff.rvalid && s_axi_rready_i) begin
      nxt_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && !st_ff.rvalid) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata  = rd_word;
      nxt_st.rresp  = rd_ok ? `PCLPC_RESP_OKAY : `PCLPC_RESP_SLVERR;
      if ((s_axi_araddr_i == `PCLPC_OFS_PLL_CONTROL) && clr_allowed) begin
        nxt_st.pll_interrupt_flag = 1'b0;
      end
    end
    if (flag_set) begin
      nxt_st.pll_interrupt_flag = 1'b1;
    end

    // Low-power mode sequencing
    case (st_ff.mode)
      pclpc_pkg::PCLPC_RUN: begin
        if (stop_exec_i) begin
          nxt_st.mode              = pclpc_pkg::PCLPC_STOP;
          nxt_st.bus_source_select = 1'b0;
        end else if (wait_exec_i) begin
          nxt_st.mode = pclpc_pkg::PCLPC_WAIT;
        end
      end
      pclpc_pkg::PCLPC_WAIT: begin
        if (wait_wake_i || irq_raw) begin
          nxt_st.mode = pclpc_pkg::PCLPC_RUN;
        end
      end
      pclpc_pkg::PCLPC_STOP: begin
        nxt_st.bus_source_select = 1'b0;
        if (stop_wake_i) begin
          nxt_st.mode = pclpc_pkg::PCLPC_RUN;
        end
      end
      default: begin
        nxt_st.mode = pclpc_pkg::PCLPC_RUN;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_ff                    <= '0;
      st_ff.mode               <= pclpc_pkg::PCLPC_RUN;
      st_ff.pll_ie             <= `PCLPC_RST_IE;
      st_ff.bus_source_select  <= `PCLPC_RST_BSS;
      st_ff.pll_power_on       <= `PCLPC_RST_PON;
      st_ff.osc_run_in_stop    <= `PCLPC_RST_ORS;
      st_ff.break_clear_enable <= `PCLPC_RST_BCE;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule

// file: test/pclpc_properties.sv
// Port-level assertions of the clock control block
`timescale 1ns/1ns
`include "pclpc_regs.svh"
module pclpc_properties (
  input wire logic        core_clk_i,
  input wire logic        arst_n_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic [7:0]  s_axi_araddr_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0]  s_axi_rresp_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        wait_exec_i,
  input wire logic        stop_exec_i,
  input wire logic        osc_enable_o,
  input wire logic        pll_enable_o,
  input wire logic        bus_source_select_o,
  input wire logic        crystal_clock_en_o,
  input wire logic        bus_clock_source_out_en_o,
  input wire logic        clock_gen_interrupt_o,
  input wire logic        wake_from_wait_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  AST_CLK_TIE: assert property (crystal_clock_en_o == osc_enable_o && bus_clock_source_out_en_o == osc_enable_o)
    else $error("Clock enables disagree");
  AST_STOP_LOW: assert property (!osc_enable_o |-> !pll_enable_o && !clock_gen_interrupt_o && !bus_source_select_o)
    else $error("Output alive while stopped");
  AST_STOP_CAUSE: assert property ($fell(osc_enable_o) |-> $past(stop_exec_i))
    else $error("Oscillator off without stop");
  AST_WAIT_KEEP: assert property (wait_exec_i && !stop_exec_i |=> $stable(osc_enable_o) && $stable(pll_enable_o) && $stable(bus_source_select_o))
    else $error("Wait changed the clock generator");
  AST_WAKE_IRQ: assert property (wake_from_wait_o |-> clock_gen_interrupt_o)
    else $error("Wake without interrupt");
  AST_WAKE_EXIT: assert property (wake_from_wait_o |=> !wake_from_wait_o)
    else $error("Wait not left after wake");
  AST_AR_ANS: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o)
    else $error("Read answer late");
  AST_AW_ANS: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o && !s_axi_bvalid_o
    |-> ##2 s_axi_bvalid_o) else $error("Write answer late");
  AST_SLVERR: assert property (s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i > `PCLPC_OFS_STATUS
    |=> s_axi_rresp_o == `PCLPC_RESP_SLVERR && s_axi_rdata_o == 32'h0) else $error("Unmapped read not refused");
endmodule

// file: test/pclpc_pll_model.sv
// Behavioural PLL that reports lock a while after it is powered
`timescale 1ns/1ns
module pclpc_pll_model #(
  parameter int LOCK_NS = 3000
) (
  input  wire logic enable_i,
  output logic      lock_o
);
  time t_on = 0;
  initial lock_o = 1'h0;
  always @(enable_i) t_on = $time;
  // Lock gained after a settle time, lost at once on power-down
  always #10 lock_o = enable_i === 1'h1 && ($time - t_on) >= LOCK_NS;
endmodule

// file: test/pll_clock_low_power_control_tb_top.sv
// Self-checking bench of the clock control block
`timescale 1ns/1ns
`include "pclpc_regs.svh"
module pll_clock_low_power_control_tb_top;
  logic        core_clk_i = 1'h0, arst_n_i = 1'h0;
  logic [7:0]  s_axi_awaddr_i = 8'h0, s_axi_araddr_i = 8'h0;
  logic [31:0] s_axi_wdata_i = 32'h0;
  logic [3:0]  s_axi_wstrb_i = 4'h0;
  logic        s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_bready_i = 1'h0;
  logic        s_axi_arvalid_i = 1'h0, s_axi_rready_i = 1'h0, break_state_i = 1'h0;
  logic        wait_exec_i = 1'h0, stop_exec_i = 1'h0, stop_wake_i = 1'h0, wait_wake_i = 1'h0;
  wire logic   pll_lock_i, s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  wire logic   osc_enable_o, pll_enable_o, bus_source_select_o, crystal_clock_en_o, bus_clock_source_out_en_o;
  wire logic   clock_gen_interrupt_o, wake_from_wait_o;
  wire logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
  wire logic [31:0] s_axi_rdata_o;
  int          bad_count = 0, n_tests = 0, cyc = 0;
  logic [31:0] rd, seed = 32'hbd20;
  logic [1:0]  rs;
  logic        cfg;
  logic [7:0]  ra [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
  logic [31:0] rv [5] = '{32'h10, 32'h0, 32'h0, 32'h1c, 32'h0};

  pclpc_top u_pclpc_top (
    .core_clk_i, .arst_n_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i,
    .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
    .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
    .wait_exec_i, .stop_exec_i, .stop_wake_i, .wait_wake_i, .break_state_i, .pll_lock_i, .osc_enable_o,
    .pll_enable_o, .bus_source_select_o, .crystal_clock_en_o, .bus_clock_source_out_en_o,
    .clock_gen_interrupt_o, .wake_from_wait_o
  );
  pclpc_pll_model u_pclpc_pll_model (.enable_i(pll_enable_o), .lock_o(pll_lock_i));

  always #25 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 8000) begin
      bad_count++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction
  // Expected clock outputs: osc, pll, source select, crystal, bus, interrupt
  function automatic logic [31:0] want(input logic stp, ors, pon, bss, irq);
    logic off;
    off = stp && !ors;
    return {26'h0, !off, pon && !stp, bss && !stp, !off, !off, irq && !off};
  endfunction
  function automatic logic [31:0] outs();
    return {26'h0, osc_enable_o, pll_enable_o, bus_source_select_o, crystal_clock_en_o, bus_clock_source_out_en_o,
      clock_gen_interrupt_o};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    logic ah, wh, dn;
    @(posedge core_clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_wstrb_i <= s;
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'h7;
    dn = 1'h0;
    while (!dn) begin
      @(negedge core_clk_i);
      ah = s_axi_awvalid_i && s_axi_awready_o;
      wh = s_axi_wvalid_i && s_axi_wready_o;
      dn = s_axi_bvalid_o === 1'h1;
      rs = s_axi_bresp_o;
      @(posedge core_clk_i);
      if (ah) s_axi_awvalid_i <= 1'h0;
      if (wh) s_axi_wvalid_i <= 1'h0;
      if (dn) s_axi_bready_i <= 1'h0;
    end
  endtask
  task automatic rdr(input logic [7:0] a);
    logic ah, dn;
    @(posedge core_clk_i);
    s_axi_araddr_i <= a;
    {s_axi_arvalid_i, s_axi_rready_i} <= 2'h3;
    dn = 1'h0;
    while (!dn) begin
      @(negedge core_clk_i);
      ah = s_axi_arvalid_i && s_axi_arready_o;
      dn = s_axi_rvalid_o === 1'h1;
      rd = s_axi_rdata_o;
      rs = s_axi_rresp_o;
      @(posedge core_clk_i);
      if (ah) s_axi_arvalid_i <= 1'h0;
      if (dn) s_axi_rready_i <= 1'h0;
    end
  endtask
  // Bits: wait, stop, stop wake, wait wake
  task automatic pulse(input logic [3:0] v);
    @(posedge core_clk_i);
    {wait_exec_i, stop_exec_i, stop_wake_i, wait_wake_i} <= v;
    @(posedge core_clk_i);
    {wait_exec_i, stop_exec_i, stop_wake_i, wait_wake_i} <= 4'h0;
    @(negedge core_clk_i);
  endtask
  task automatic raise_flag;
    wr(`PCLPC_OFS_PLL_CONTROL, 32'h1);
    repeat (70) @(posedge core_clk_i);
    rdr(`PCLPC_OFS_PLL_CONTROL);
    wr(`PCLPC_OFS_PLL_CONTROL, 32'h11);
    for (int i = 0; i < 150 && clock_gen_interrupt_o !== 1'h1; i++) @(negedge core_clk_i);
    chk("irq_set", 32'h1, {31'h0, clock_gen_interrupt_o});
  endtask
  task automatic conclude;
    $display("Comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge core_clk_i);
    arst_n_i <= 1'h1;
    @(negedge core_clk_i);
    chk("outs_reset", want(0, 0, 1, 0, 0), outs());
    foreach (ra[i]) begin
      rdr(ra[i]);
      chk("reset_val", rv[i], rd);
      chk("rresp", (i == 4) ? `PCLPC_RESP_SLVERR : `PCLPC_RESP_OKAY, rs);
    end
    wr(8'h10, 32'h1f);
    chk("bresp_unmapped", `PCLPC_RESP_SLVERR, rs);
    wr(`PCLPC_OFS_PLL_CONTROL, 32'h18);
    chk("bresp", `PCLPC_RESP_OKAY, rs);
    chk("bss_unlocked", want(0, 0, 1, 1, 0), outs());
    rdr(`PCLPC_OFS_PLL_CONTROL);
    chk("pll_control_reg_unlocked", 32'h18, rd);
    cfg = 1'h0;
    repeat (6) begin
      seed = xs(seed);
      wr(`PCLPC_OFS_CONFIG, seed, seed[7:4]);
      if (seed[4]) cfg = seed[0];
      rdr(`PCLPC_OFS_CONFIG);
      chk("config", {31'h0, cfg}, rd);
    end
    wr(`PCLPC_OFS_CONFIG, 32'h0);
    repeat (80) @(posedge core_clk_i);
    rdr(`PCLPC_OFS_PLL_CONTROL);
    chk("pll_control_reg_locked", 32'h1e, rd);
    rdr(`PCLPC_OFS_PLL_CONTROL);
    chk("flag_clear", 32'h1c, rd);
    foreach (rv[i]) begin
      if (i > 2) break;
      rd = (i == 0) ? 32'h18 : (i == 1) ? 32'h10 : 32'h0;
      wr(`PCLPC_OFS_PLL_CONTROL, rd);
      pulse(4'h8);
      chk("outs_wait", want(0, 0, rd[4], rd[3], 0), outs());
      rdr(`PCLPC_OFS_STATUS);
      chk("status_wait", 32'h15 | (rv[0] == 32'h10 ? 32'h0 : 32'h0) | {28'h0, (i < 2), 3'h0}, rd);
      pulse(4'h1);
      rdr(`PCLPC_OFS_STATUS);
      chk("status_woken", 32'h14 | {28'h0, (i < 2), 3'h0}, rd);
    end
    wr(`PCLPC_OFS_PLL_CONTROL, 32'h11);
    pulse(4'h8);
    for (int i = 0; i < 150 && wake_from_wait_o !== 1'h1; i++) @(negedge core_clk_i);
    chk("wake", 32'h1, {31'h0, wake_from_wait_o});
    @(negedge core_clk_i);
    chk("wake_exit", 32'h0, {31'h0, wake_from_wait_o});
    rdr(`PCLPC_OFS_PLL_CONTROL);
    chk("irq_clear", want(0, 0, 1, 0, 0), outs());
    for (int o = 0; o < 2; o++) begin
      wr(`PCLPC_OFS_CONFIG, o);
      wr(`PCLPC_OFS_PLL_CONTROL, 32'h18);
      pulse(4'h4);
      chk("outs_stop", want(1, o, 1, 1, 0), outs());
      pulse(4'h2);
      chk("outs_resume", want(0, o, 1, 0, 0), outs());
      rdr(`PCLPC_OFS_PLL_CONTROL);
      chk("bss_resume", 32'h0, rd & 32'h8);
    end
    wr(`PCLPC_OFS_CONFIG, 32'h0);
    for (int b = 0; b < 2; b++) begin
      wr(`PCLPC_OFS_BREAK_FLAG, b);
      raise_flag();
      @(posedge core_clk_i);
      break_state_i <= 1'h1;
      rdr(`PCLPC_OFS_PLL_CONTROL);
      wr(`PCLPC_OFS_PLL_CONTROL, 32'h13);
      chk("irq_break", {31'h0, b == 0}, {31'h0, clock_gen_interrupt_o});
      @(posedge core_clk_i);
      break_state_i <= 1'h0;
      repeat (2) @(negedge core_clk_i);
      chk("irq_after", {31'h0, b == 0}, {31'h0, clock_gen_interrupt_o});
      rdr(`PCLPC_OFS_PLL_CONTROL);
      chk("irq_read", 32'h0, {31'h0, clock_gen_interrupt_o});
    end
    conclude();
  end
endmodule

bind pclpc_top pclpc_properties u_pclpc_properties (
  .core_clk_i, .arst_n_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o,
  .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
  .wait_exec_i, .stop_exec_i, .osc_enable_o, .pll_enable_o, .bus_source_select_o, .crystal_clock_en_o,
  .bus_clock_source_out_en_o, .clock_gen_interrupt_o, .wake_from_wait_o
);
